// ==== tb/bit_toggle_branch_call_clear_exec_tb_top.sv ====
// Purpose: self-checking bench for the bit invert, branch, call and clear execute block
// Assumes: QUARTER_CLKS of 1, so one instruction cycle is four clocks
// Notes:   programs are loaded into the memory model while the core is halted
`timescale 1ns/1ns
`default_nettype none

module bit_toggle_branch_call_clear_exec_tb_top;
	logic        sys_clk;
	logic        nrst;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [20:0] prog_addr;
	logic [15:0] prog_word;
	logic [11:0] dmem_addr;
	logic        dmem_rd;
	logic [7:0]  dmem_rdata;
	logic        dmem_we;
	logic [7:0]  dmem_wdata;
	int          failures = 0;
	int          n_checks = 0;
	logic        stack_push;
	logic [20:0] return_stack_top;
	int          n_push = 0;

	bit_toggle_branch_call_clear_exec #(.QUARTER_CLKS(1)) dut (
		.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_addr(prog_addr), .prog_word(prog_word), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
		.dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
		.stack_push(stack_push), .return_stack_top(return_stack_top)
	);

	prog_data_mem_model mem (
		.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_word(prog_word), .dmem_addr(dmem_addr),
		.dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata)
	);

	// ***************************************************************
	// shared tasks
	// ***************************************************************
	task automatic check(input bit ok, input string msg);
		n_checks++;
		if (!ok) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) check(1'b0, "apb ready never came");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		check(e === exp_err && (exp_err || r === exp), "register read");
	endtask

	// halt, load pc, run for a fixed span, halt again
	task automatic run_prog(input logic [20:0] base, input logic ext, input int clocks);
		wr(exec_core_pkg::REG_CTRL, 32'h00000000);
		repeat (8) @(posedge sys_clk);
		wr(exec_core_pkg::REG_PC, {11'h000, base});
		mem.log_addr.delete();
		mem.log_data.delete();
		mem.log_clk.delete();
		wr(exec_core_pkg::REG_CTRL, {30'h00000000, ext, 1'b1});
		repeat (clocks) @(posedge sys_clk);
		wr(exec_core_pkg::REG_CTRL, 32'h00000000);
	endtask

	function automatic logic [15:0] inv_w(input logic [2:0] b, input logic a, input logic [7:0] f);
		return {exec_core_pkg::OP_BIT_INVERT, b, a, f};
	endfunction

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_reset_regs;
		for (int i = 0; i < 8; i++) begin
			rdchk(8'(i * 4), 32'h00000000, 1'b0);
		end
		rdchk(8'h20, 32'h00000000, 1'b1);
	endtask

	task automatic t_invert(input logic a, input logic ext, input logic [3:0] bank,
			input logic [11:0] idx, input logic [7:0] f, input logic [2:0] b, input logic [11:0] exp);
		mem.pmem.delete();
		mem.pmem[0] = inv_w(b, a, f);
		mem.dmem[exp] <= 8'h75;
		wr(exec_core_pkg::REG_BANK, {28'h0000000, bank});
		wr(exec_core_pkg::REG_INDEX, {20'h00000, idx});
		run_prog(21'h000000, ext, 40);
		check(mem.log_addr.size() == 1 && mem.log_addr[0] === exp
			&& mem.log_data[0] === (8'h75 ^ (8'h01 << b)), "bit invert result");
	endtask

	task automatic t_branch(input logic [7:0] op, input logic [7:0] n, input logic [20:0] base,
			input logic [4:0] st, input bit taken);
		logic [20:0] tgt;
		tgt = base + 21'h000004 + {{12{n[7]}}, n, 1'b0};
		mem.pmem.delete();
		mem.pmem[int'(base[20:1])] = inv_w(3'h0, 1'b0, 8'h01);
		mem.pmem[int'(base[20:1]) + 1] = {op, n};
		mem.pmem[int'(base[20:1]) + 2] = inv_w(3'h0, 1'b0, 8'h02);
		mem.pmem[int'(tgt[20:1])] = inv_w(3'h0, 1'b0, 8'h03);
		wr(exec_core_pkg::REG_STATUS, {27'h0000000, st});
		run_prog(base, 1'b0, 80);
		check(mem.log_addr.size() >= 2 && mem.log_addr[0] === 12'h001
			&& mem.log_addr[1] === (taken ? 12'h003 : 12'h002)
			&& mem.log_clk[1] - mem.log_clk[0] == (taken ? 12 : 8), "branch path or timing");
		rdchk(exec_core_pkg::REG_STATUS, {27'h0000000, st}, 1'b0);
	endtask

	task automatic t_call(input logic s, input logic [7:0] acc, input logic [31:0] exp_sh);
		int p;
		mem.pmem.delete();
		mem.pmem[32'h20] = inv_w(3'h0, 1'b0, 8'h01);
		mem.pmem[32'h21] = {exec_core_pkg::OP_CALL, s, 8'h10};
		mem.pmem[32'h22] = 16'hF800;
		mem.pmem[32'h23] = inv_w(3'h0, 1'b0, 8'h02);
		mem.pmem[32'h80010] = inv_w(3'h0, 1'b0, 8'h03);
		wr(exec_core_pkg::REG_ACC, {24'h000000, acc});
		wr(exec_core_pkg::REG_BANK, 32'h00000009);
		wr(exec_core_pkg::REG_STATUS, 32'h00000011);
		p = n_push;
		run_prog(21'h000040, 1'b0, 80);
		check(n_push == p + 1 && return_stack_top === 21'h000046, "one push with return address");
		check(mem.log_addr.size() >= 2 && mem.log_addr[1] === 12'h003
			&& mem.log_clk[1] - mem.log_clk[0] == 12, "call target or timing");
		rdchk(exec_core_pkg::REG_STACK, 32'h00000046, 1'b0);
		rdchk(exec_core_pkg::REG_SHADOW, exp_sh, 1'b0);
		rdchk(exec_core_pkg::REG_STATUS, 32'h00000011, 1'b0);
	endtask

	task automatic t_clear;
		mem.pmem.delete();
		mem.pmem[0] = {exec_core_pkg::OP_CLEAR_FILE, 1'b1, 8'h44};
		mem.dmem[12'h244] <= 8'hC3;
		wr(exec_core_pkg::REG_BANK, 32'h00000002);
		wr(exec_core_pkg::REG_STATUS, 32'h00000000);
		run_prog(21'h000000, 1'b0, 40);
		check(mem.log_addr.size() == 1 && mem.log_addr[0] === 12'h244
			&& mem.log_data[0] === 8'h00, "clear file write");
		rdchk(exec_core_pkg::REG_STATUS, 32'h00000004, 1'b0);
	endtask

	// ***************************************************************
	// clock, reset, sequence, watchdog
	// ***************************************************************
	always @(posedge sys_clk) begin
		if (stack_push === 1'b1) begin
			n_push <= n_push + 1;
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial begin
		nrst    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset_regs();
		t_invert(1'b0, 1'b0, 4'h0, 12'h000, 8'h25, 3'h4, 12'h025);
		t_invert(1'b0, 1'b0, 4'h0, 12'h000, 8'h80, 3'h0, 12'hF80);
		t_invert(1'b1, 1'b0, 4'h3, 12'h000, 8'h10, 3'h7, 12'h310);
		t_invert(1'b0, 1'b1, 4'h3, 12'h200, 8'h10, 3'h2, 12'h210);
		t_invert(1'b0, 1'b1, 4'h3, 12'hFF0, 8'h5F, 3'h6, 12'h04F);
		t_invert(1'b0, 1'b1, 4'h3, 12'h200, 8'h60, 3'h1, 12'hF60);
		t_invert(1'b1, 1'b1, 4'h5, 12'h200, 8'h10, 3'h3, 12'h510);
		t_branch(8'hE0, 8'h05, 21'h000000, 5'h04, 1'b1);
		t_branch(8'hE0, 8'h7F, 21'h000000, 5'h1B, 1'b0);
		t_branch(8'hE4, 8'h80, 21'h000200, 5'h08, 1'b1);
		t_branch(8'hE4, 8'h7F, 21'h000000, 5'h17, 1'b0);
		t_branch(8'hE4, 8'h7F, 21'h000000, 5'h08, 1'b1);
		t_call(1'b1, 8'hA5, 32'h000131A5);
		t_call(1'b0, 8'h3C, 32'h000131A5);
		t_clear();
		close_out();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		close_out();
	end
endmodule

`default_nettype wire

// ==== tb/prog_data_mem_model.sv ====
// Purpose: program and data memory seen from the execute block's fetch and data ports
// Assumes: same-clock combinational reads, writes on the rising edge
// Notes:   unloaded program words read as 0000, which executes as no operation
`timescale 1ns/1ns
`default_nettype none

module prog_data_mem_model (
	input  wire logic        sys_clk,
	input  wire logic [20:0] prog_addr,
	output var  logic [15:0] prog_word,
	input  wire logic [11:0] dmem_addr,
	input  wire logic        dmem_rd,
	output var  logic [7:0]  dmem_rdata,
	input  wire logic        dmem_we,
	input  wire logic [7:0]  dmem_wdata
);
	logic [15:0] pmem [int];
	logic [7:0]  dmem [4096];
	logic [11:0] log_addr [$];
	logic [7:0]  log_data [$];
	int          log_clk [$];
	int          clk_n = 0;

	// refreshed on the falling edge too, so words loaded at an unchanged address are seen
	always @(prog_addr or negedge sys_clk) begin
		prog_word = pmem.exists(int'(prog_addr[20:1])) ? pmem[int'(prog_addr[20:1])] : 16'h0000;
	end

	assign dmem_rdata = dmem[dmem_addr];

	// every write is logged with its clock number so the bench can measure cycle spacing
	always @(posedge sys_clk) begin
		clk_n <= clk_n + 1;
		if (dmem_we === 1'b1) begin
			dmem[dmem_addr] <= dmem_wdata;
			log_addr.push_back(dmem_addr);
			log_data.push_back(dmem_wdata);
			log_clk.push_back(clk_n);
		end
	end
endmodule

`default_nettype wire

// ==== verilog/bit_toggle_branch_call_clear_exec.sv ====
// Purpose: executes bit invert, two conditional branches, call and clear file
// Assumes: prog_word and dmem_rdata come from logic on sys_clk
// Notes:   pc is the next fetch address; ir holds the prefetched word
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module bit_toggle_branch_call_clear_exec #(
	parameter int unsigned QUARTER_CLKS = exec_core_pkg::QUARTER_CLKS
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic [20:0] prog_addr,
	input  wire logic [15:0] prog_word,
	output var  logic [11:0] dmem_addr,
	output var  logic        dmem_rd,
	input  wire logic [7:0]  dmem_rdata,
	output var  logic        dmem_we,
	output var  logic [7:0]  dmem_wdata,
	output var  logic        stack_push,
	output var  logic [20:0] return_stack_top
);
	// ***************************************************************
	// state
	// ***************************************************************
	exec_core_pkg::exec_state_t state;
	exec_core_pkg::exec_state_t next_state;
	logic [1:0]  ctrl;
	logic [1:0]  next_ctrl;
	logic [4:0]  status;
	logic [4:0]  next_status;
	logic [3:0]  bank_select_register;
	logic [3:0]  next_bank_select_register;
	logic [7:0]  acc;
	logic [7:0]  next_acc;
	logic [11:0] index_base;
	logic [11:0] next_index_base;
	logic [20:0] pc;
	logic [20:0] next_pc;
	logic [15:0] ir;
	logic [15:0] next_ir;
	logic [7:0]  accumulator_shadow;
	logic [7:0]  next_accumulator_shadow;
	logic [4:0]  flags_shadow;
	logic [4:0]  next_flags_shadow;
	logic [3:0]  bank_select_shadow;
	logic [3:0]  next_bank_select_shadow;
	logic [11:0] next_dmem_addr;
	logic [7:0]  next_dmem_wdata;
	logic        next_stack_push;
	logic [20:0] next_return_stack_top;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	// ***************************************************************
	// decode
	// ***************************************************************
	logic        is_exec;
	logic        bit_invert_op;
	logic        clear_file_op;
	logic        branch_on_overflow_op;
	logic        branch_on_zero_op;
	logic        call_op;
	logic        fast_save;
	logic        flag_z;
	logic        flag_ov;
	logic        take_branch;
	logic        redirect;
	logic [7:0]  file_field;
	logic [7:0]  bit_mask;
	logic [20:0] branch_target;
	logic [20:0] call_target;
	logic        apb_wr;

	exec_core_if io ();

	quarter_phase_gen #(
		.QUARTER_CLKS (QUARTER_CLKS)
	) u_phase (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.ph      (io.phase_gen)
	);

	file_addr_map u_addr (
		.am (io.addr_map)
	);

	assign is_exec = (state == exec_core_pkg::ST_EXEC);
	assign bit_invert_op = (ir[15:12] == exec_core_pkg::OP_BIT_INVERT);
	assign clear_file_op = (ir[15:9] == exec_core_pkg::OP_CLEAR_FILE);
	assign branch_on_overflow_op = (ir[15:8] == exec_core_pkg::OP_BRANCH_OVERFLOW);
	assign branch_on_zero_op = (ir[15:8] == exec_core_pkg::OP_BRANCH_ZERO);
	assign call_op = (ir[15:9] == exec_core_pkg::OP_CALL);
	assign fast_save = ir[8];
	assign flag_z = status[exec_core_pkg::ST_Z];
	assign flag_ov = status[exec_core_pkg::ST_OV];
	assign take_branch = (branch_on_overflow_op && flag_ov) || (branch_on_zero_op && flag_z);
	assign redirect = take_branch || call_op;
	assign file_field = ir[7:0];
	assign bit_mask = 8'h01 << ir[11:9];
	assign branch_target = pc + {{12{ir[7]}}, ir[7:0], 1'b0};
	assign call_target = {prog_word[11:0], ir[7:0], 1'b0};
	assign apb_wr = psel && penable && pwrite;

	assign io.run = ctrl[exec_core_pkg::CTRL_RUN];
	assign io.access = ir[8];
	assign io.ext_en = ctrl[exec_core_pkg::CTRL_EXT];
	assign io.bank = bank_select_register;
	assign io.index_base = index_base;
	assign io.file_addr = file_field;

	// ***************************************************************
	// data memory strobes
	// ***************************************************************
	assign prog_addr = pc;
	assign dmem_rd = is_exec && io.q[1] && bit_invert_op;
	assign dmem_we = is_exec && io.q[3] && (bit_invert_op || clear_file_op);
	assign pready = penable;

	// ***************************************************************
	// core sequencing and register writes
	// ***************************************************************
	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_status = status;
		next_bank_select_register = bank_select_register;
		next_acc = acc;
		next_index_base = index_base;
		next_pc = pc;
		next_ir = ir;
		next_accumulator_shadow = accumulator_shadow;
		next_flags_shadow = flags_shadow;
		next_bank_select_shadow = bank_select_shadow;
		next_dmem_addr = dmem_addr;
		next_dmem_wdata = dmem_wdata;
		next_stack_push = 1'b0;
		next_return_stack_top = return_stack_top;
		if (apb_wr) begin
			case (paddr)
				exec_core_pkg::REG_CTRL: next_ctrl = pwdata[1:0];
				exec_core_pkg::REG_STATUS: next_status = pwdata[4:0];
				exec_core_pkg::REG_BANK: next_bank_select_register = pwdata[3:0];
				exec_core_pkg::REG_ACC: next_acc = pwdata[7:0];
				exec_core_pkg::REG_INDEX: next_index_base = pwdata[11:0];
				exec_core_pkg::REG_PC: begin
					if (state == exec_core_pkg::ST_HALT) begin
						next_pc = {pwdata[20:1], 1'b0};
					end
				end
				default: begin
				end
			endcase
		end
		case (state)
			exec_core_pkg::ST_HALT: begin
				next_ir = exec_core_pkg::NOP_WORD;
				if (ctrl[exec_core_pkg::CTRL_RUN]) begin
					next_state = exec_core_pkg::ST_FILL;
				end
			end
			exec_core_pkg::ST_FILL, exec_core_pkg::ST_EXEC: begin
				if (!ctrl[exec_core_pkg::CTRL_RUN]) begin
					next_state = exec_core_pkg::ST_HALT;
				end else begin
					if (io.q[0]) begin
						next_dmem_addr = io.eff_addr;
					end
					if (io.q[2] && is_exec) begin
						if (bit_invert_op) begin
							next_dmem_wdata = dmem_rdata ^ bit_mask;
						end
						if (clear_file_op) begin
							next_dmem_wdata = 8'h00;
						end
						if (call_op) begin
							next_stack_push = 1'b1;
							next_return_stack_top = pc + 21'h000002;
							if (fast_save) begin
								next_accumulator_shadow = acc;
								next_flags_shadow = status;
								next_bank_select_shadow = bank_select_register;
							end
						end
					end
					if (io.q[3]) begin
						if (is_exec && clear_file_op) begin
							next_status[exec_core_pkg::ST_Z] = 1'b1;
						end
						if (is_exec && redirect) begin
							next_pc = take_branch ? branch_target : call_target;
							next_ir = exec_core_pkg::NOP_WORD;
							next_state = exec_core_pkg::ST_FILL;
						end else begin
							next_ir = prog_word;
							next_pc = pc + 21'h000002;
							next_state = exec_core_pkg::ST_EXEC;
						end
					end
				end
			end
			default: next_state = exec_core_pkg::ST_HALT;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= exec_core_pkg::ST_HALT;
			ctrl <= exec_core_pkg::CTRL_RST;
			status <= exec_core_pkg::STATUS_RST;
			bank_select_register <= exec_core_pkg::BANK_RST;
			acc <= exec_core_pkg::ACC_RST;
			index_base <= exec_core_pkg::INDEX_RST;
			pc <= exec_core_pkg::PC_RST;
			ir <= exec_core_pkg::NOP_WORD;
			accumulator_shadow <= exec_core_pkg::ACC_RST;
			flags_shadow <= exec_core_pkg::STATUS_RST;
			bank_select_shadow <= exec_core_pkg::BANK_RST;
			dmem_addr <= exec_core_pkg::INDEX_RST;
			dmem_wdata <= exec_core_pkg::ACC_RST;
			stack_push <= 1'b0;
			return_stack_top <= exec_core_pkg::PC_RST;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			status <= next_status;
			bank_select_register <= next_bank_select_register;
			acc <= next_acc;
			index_base <= next_index_base;
			pc <= next_pc;
			ir <= next_ir;
			accumulator_shadow <= next_accumulator_shadow;
			flags_shadow <= next_flags_shadow;
			bank_select_shadow <= next_bank_select_shadow;
			dmem_addr <= next_dmem_addr;
			dmem_wdata <= next_dmem_wdata;
			stack_push <= next_stack_push;
			return_stack_top <= next_return_stack_top;
		end
	end

	// ***************************************************************
	// apb read path
	// ***************************************************************
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (psel && !penable) begin
			next_prdata = 32'h00000000;
			next_pslverr = 1'b0;
			case (paddr)
				exec_core_pkg::REG_CTRL: next_prdata = {30'h00000000, ctrl};
				exec_core_pkg::REG_STATUS: next_prdata = {27'h0000000, status};
				exec_core_pkg::REG_BANK: next_prdata = {28'h0000000, bank_select_register};
				exec_core_pkg::REG_ACC: next_prdata = {24'h000000, acc};
				exec_core_pkg::REG_INDEX: next_prdata = {20'h00000, index_base};
				exec_core_pkg::REG_PC: next_prdata = {11'h000, pc};
				exec_core_pkg::REG_SHADOW: begin
					next_prdata = {15'h0000, bank_select_shadow, flags_shadow, accumulator_shadow};
				end
				exec_core_pkg::REG_STACK: next_prdata = {11'h000, return_stack_top};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_exec_q3;
		is_exec && io.q[2];
	endsequence

	sequence s_exec_q4;
		is_exec && io.q[3];
	endsequence

	sequence s_redirect;
		s_exec_q4 ##0 redirect;
	endsequence

	AST_BIT_INVERT: assert property (s_exec_q3 ##0 bit_invert_op |=> dmem_wdata == ($past(dmem_rdata) ^ $past(bit_mask)))
		else $error("bit invert wrote wrong byte");
	AST_BANK_MAP: assert property (is_exec && io.q[0] && ir[8] |=> dmem_addr == {$past(bank_select_register), $past(file_field)})
		else $error("banked address wrong");
	AST_LIT_OFFSET: assert property (is_exec && io.q[0] && !ir[8] && io.ext_en && file_field <= exec_core_pkg::LIT_OFFSET_MAX
		|=> dmem_addr == $past(index_base) + {4'h0, $past(file_field)})
		else $error("indexed offset address wrong");
	AST_OVERFLOW_COND: assert property (s_exec_q4 ##0 branch_on_overflow_op |=> (state == exec_core_pkg::ST_FILL) == $past(flag_ov))
		else $error("overflow branch decision wrong");
	AST_ZERO_FALL: assert property (s_exec_q4 ##0 branch_on_zero_op && !flag_z
		|=> pc == $past(pc) + 21'h000002 && state == exec_core_pkg::ST_EXEC)
		else $error("untaken zero branch did not fall through");
	AST_BRANCH_TARGET: assert property (s_exec_q4 ##0 take_branch |=> pc == $past(branch_target) && ir == 16'h0000)
		else $error("branch target wrong");
	AST_FLAGS_KEPT: assert property (is_exec && (branch_on_overflow_op || branch_on_zero_op || call_op) && !apb_wr
		|=> status == $past(status))
		else $error("branch or call changed flags");
	AST_CALL_PUSH: assert property (s_exec_q3 ##0 call_op |=> stack_push && return_stack_top == $past(pc) + 21'h000002)
		else $error("call return address wrong");
	AST_SHADOW_HOLD: assert property (s_exec_q3 ##0 call_op && !fast_save
		|=> accumulator_shadow == $past(accumulator_shadow) && flags_shadow == $past(flags_shadow))
		else $error("shadow changed without fast save");
	AST_CALL_TARGET: assert property (s_exec_q4 ##0 call_op |=> pc == $past(call_target))
		else $error("call target wrong");
	AST_REDIRECT_NOP: assert property (s_redirect |=> state == exec_core_pkg::ST_FILL ##1 !dmem_we)
		else $error("redirect did not insert empty cycle");
	AST_CLEAR_FILE: assert property (s_exec_q4 ##0 clear_file_op |-> dmem_we && dmem_wdata == 8'h00 ##1 flag_z)
		else $error("clear file wrong");
	AST_FILL_QUIET: assert property (state == exec_core_pkg::ST_FILL |-> !dmem_we && !dmem_rd)
		else $error("discarded word acted");
endmodule

`default_nettype wire

// ==== verilog/exec_core_if.sv ====
// Purpose: carries quarter strobes and operand addressing between core parts
// Assumes: single clock domain
// Notes:   q is one-hot, bit 0 is the first quarter
`timescale 1ns/1ns
`default_nettype none

interface exec_core_if;
	logic        run;
	logic [3:0]  q;
	logic        access;
	logic        ext_en;
	logic [3:0]  bank;
	logic [11:0] index_base;
	logic [7:0]  file_addr;
	logic [11:0] eff_addr;

	modport phase_gen (input run, output q);
	modport addr_map (input access, ext_en, bank, index_base, file_addr, output eff_addr);
	modport exec_ctl (output run, access, ext_en, bank, index_base, file_addr, input q, eff_addr);
endinterface

`default_nettype wire

// ==== verilog/exec_core_pkg.sv ====
// Purpose: constants and types shared by the instruction execute block
// Assumes: 16-bit instruction words, 21-bit byte program counter, 12-bit data address
// Notes:   register offsets are byte addresses on a 32-bit APB
`default_nettype none

package exec_core_pkg;

	// ***************************************************************
	// widths and timing
	// ***************************************************************
	localparam int unsigned PC_W         = 21;
	localparam int unsigned DADDR_W      = 12;
	localparam int unsigned QUARTER_CLKS = 1;

	// ***************************************************************
	// opcodes
	// ***************************************************************
	localparam logic [3:0]  OP_BIT_INVERT      = 4'h7;
	localparam logic [6:0]  OP_CLEAR_FILE      = 7'h35;
	localparam logic [7:0]  OP_BRANCH_OVERFLOW = 8'hE4;
	localparam logic [7:0]  OP_BRANCH_ZERO     = 8'hE0;
	localparam logic [6:0]  OP_CALL            = 7'h76;
	localparam logic [15:0] NOP_WORD           = 16'h0000;

	// ***************************************************************
	// data addressing
	// ***************************************************************
	localparam logic [7:0] LIT_OFFSET_MAX   = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT     = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

	// ***************************************************************
	// status and control fields
	// ***************************************************************
	localparam int unsigned ST_C     = 0;
	localparam int unsigned ST_DC    = 1;
	localparam int unsigned ST_Z     = 2;
	localparam int unsigned ST_OV    = 3;
	localparam int unsigned ST_N     = 4;
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_EXT = 1;

	// ***************************************************************
	// register offsets and reset values
	// ***************************************************************
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_STATUS = 8'h04;
	localparam logic [7:0]  REG_BANK   = 8'h08;
	localparam logic [7:0]  REG_ACC    = 8'h0C;
	localparam logic [7:0]  REG_INDEX  = 8'h10;
	localparam logic [7:0]  REG_PC     = 8'h14;
	localparam logic [7:0]  REG_SHADOW = 8'h18;
	localparam logic [7:0]  REG_STACK  = 8'h1C;
	localparam logic [1:0]  CTRL_RST   = 2'h0;
	localparam logic [4:0]  STATUS_RST = 5'h00;
	localparam logic [3:0]  BANK_RST   = 4'h0;
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [11:0] INDEX_RST  = 12'h000;
	localparam logic [20:0] PC_RST     = 21'h000000;

	typedef enum logic [1:0] {ST_HALT, ST_FILL, ST_EXEC} exec_state_t;

endpackage

`default_nettype wire

// ==== verilog/file_addr_map.sv ====
// Purpose: forms the 12-bit data address of a file-register operand
// Assumes: operands are stable for the whole instruction cycle
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none

module file_addr_map (
	exec_core_if.addr_map am
);
	logic lit_mode;

	always_comb begin
		lit_mode = !am.access && am.ext_en && (am.file_addr <= exec_core_pkg::LIT_OFFSET_MAX);
		if (am.access) begin
			am.eff_addr = {am.bank, am.file_addr};
		end else if (lit_mode) begin
			am.eff_addr = am.index_base + {4'h0, am.file_addr};
		end else if (am.file_addr < exec_core_pkg::ACCESS_SPLIT) begin
			am.eff_addr = {4'h0, am.file_addr};
		end else begin
			am.eff_addr = {exec_core_pkg::ACCESS_HIGH_BANK, am.file_addr};
		end
	end
endmodule

`default_nettype wire

// ==== verilog/quarter_phase_gen.sv ====
// Purpose: divides the core clock into four quarter strobes per instruction cycle
// Assumes: run comes from logic on the same clock
// Notes:   stopping run parks the divider at the first quarter
`timescale 1ns/1ns
`default_nettype none

module quarter_phase_gen #(
	parameter int unsigned QUARTER_CLKS = exec_core_pkg::QUARTER_CLKS
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	exec_core_if.phase_gen  ph
);
	logic [7:0] div;
	logic [7:0] next_div;
	logic [1:0] phase;
	logic [1:0] next_phase;

	always_comb begin
		next_div = div;
		next_phase = phase;
		if (!ph.run) begin
			next_div = 8'h00;
			next_phase = 2'h0;
		end else if (div == 8'(QUARTER_CLKS - 1)) begin
			next_div = 8'h00;
			next_phase = phase + 2'h1;
		end else begin
			next_div = div + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			div <= 8'h00;
			phase <= 2'h0;
		end else begin
			div <= next_div;
			phase <= next_phase;
		end
	end

	assign ph.q = (ph.run && div == 8'h00) ? (4'h1 << phase) : 4'h0;
endmodule

`default_nettype wire
